// ### rtl/secure_remap_map.vh
// constants of the secure access remap unit: offsets, fields, resets
// assumes byte offsets on both buses, 32-bit data words

`ifndef SECURE_REMAP_MAP_VH
`define SECURE_REMAP_MAP_VH

// peripheral bus offsets
`define CTRL_OFF      8'h00
`define CONFIG_OFF    8'h04
`define EN_HIGH_OFF   8'h08
`define EN_LOW_OFF    8'h0c
`define STATUS_OFF    8'h10
`define MASK_SET_OFF  8'h14
`define MASK_CLR_OFF  8'h18
`define MASK_OFF      8'h1c
`define FLAG_CLR_OFF  8'h20
`define PARAM_OFF     8'h24
`define VERSION_OFF   8'h28

// fast bus offsets
`define UNLOCK_OFF    8'hfc

// control bits
`define CTL_EN        0
`define CTL_DIS       1
`define CTL_SETUP_ON  2
`define CTL_SETUP_OFF 3
`define CTL_BERR_ON   4
`define CTL_BERR_OFF  5

// configuration fields
`define CFG_WIN_HI    15
`define CFG_WIN_LO    8
`define CFG_KEY_HI    7
`define CFG_KEY_LO    0
`define CFG_OPEN      16

// unlock port fields
`define UR_KEY_HI     7
`define UR_KEY_LO     0
`define UR_CH_HI      13
`define UR_CH_LO      8

// status flag positions
`define F_TIMEOUT     0
`define F_SUCCESS     1
`define F_DENIED      2
`define F_UNLOCK_PORT_READ_FLAG      3
`define F_BADKEY      4
`define F_BLOCKED     5
`define F_MBERR       6
`define F_REMAP       7
`define ERR_MASK      8'hfd

// lowest legal remap target, upper half
`define REMAP_FLOOR   16'hfffc

// implementation values; version value is arbitrary
`define CHANNELS      8
`define PARAM_VAL     32'h00000008
`define VERSION_VAL   32'h00000100
`define RESET_WORD    32'h00000000

`endif

// ### rtl/status_flags.v
// status flags, interrupt mask and interrupt request
// assumes set pulses and write strobes are one cycle, synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "secure_remap_map.vh"

module status_flags (
    // clock, reset, enable
    input  wire       ref_clk,
    input  wire       nrst,
    input  wire       clk_en,
    // events
    input  wire [7:0] set_ev,
    // register writes
    input  wire       mask_set_wr,
    input  wire       mask_clr_wr,
    input  wire       flag_clr_wr,
    input  wire [7:0] wr_bits,
    // state
    output wire [7:0] flags,
    output wire [7:0] mask,
    output wire       irq
);
    reg [7:0] flags_reg;
    reg [7:0] mask_reg;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            flags_reg <= 8'h00;
            mask_reg  <= 8'h00;
        end else if (clk_en) begin
            // set wins over a clear in the same cycle
            flags_reg <= (flags_reg & ~({8{flag_clr_wr}} & wr_bits)) | set_ev;
            if (mask_set_wr)
                mask_reg <= mask_reg | wr_bits;
            else if (mask_clr_wr)
                mask_reg <= mask_reg & ~wr_bits;
        end
    end

    assign flags = flags_reg;
    assign mask  = mask_reg;
    assign irq   = |(flags_reg & mask_reg);

endmodule // status_flags
`default_nettype wire

// ### rtl/unlock_timer.v
// unlock window: which channel is open and for how long
// assumes unlock_go and consume are one-cycle strobes, drop a level, all synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none

module unlock_timer (
    // clock, reset, enable
    input  wire       ref_clk,
    input  wire       nrst,
    input  wire       clk_en,
    // control
    input  wire       unlock_go,
    input  wire [5:0] unlock_chan,
    input  wire [7:0] window_len,
    input  wire       consume,
    input  wire       drop,
    // state
    output wire       unlocked,
    output wire [5:0] cur_chan,
    output wire       expired
);
    reg       open_reg;
    reg [5:0] chan_reg;
    reg [7:0] count_reg;

    assign expired = clk_en & open_reg & ~consume & ~unlock_go & ~drop
                     & (count_reg == 8'h00);

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            open_reg  <= 1'b0;
            chan_reg  <= 6'h00;
            count_reg <= 8'h00;
        end else if (clk_en) begin
            if (drop) begin
                open_reg <= 1'b0;
            end else if (unlock_go) begin
                // a new unlock relocks whatever channel was open
                open_reg  <= 1'b1;
                chan_reg  <= unlock_chan;
                count_reg <= window_len;
            end else if (open_reg) begin
                if (consume || count_reg == 8'h00)
                    open_reg <= 1'b0;
                else
                    count_reg <= count_reg - 8'h01;
            end
        end
    end

    assign unlocked = open_reg;
    assign cur_chan = chan_reg;

endmodule // unlock_timer
`default_nettype wire

// ### rtl/secure_access_remap.v
// secure access remap unit: configuration port, fast bus slave and master
// assumes single-clock buses; requests hold until hs_ready, m_req until m_done
`timescale 1ns/1ps
`default_nettype none
`include "secure_remap_map.vh"

module secure_access_remap (
    // clock, reset, enable
    input  wire        ref_clk,
    input  wire        nrst,
    input  wire        clk_en,
    // peripheral bus configuration port
    input  wire        pb_sel,
    input  wire        pb_write,
    input  wire [7:0]  pb_addr,
    input  wire [31:0] pb_wdata,
    output wire [31:0] pb_rdata,
    // high speed bus slave port
    input  wire        hs_req,
    input  wire        hs_write,
    input  wire [7:0]  hs_addr,
    input  wire [31:0] hs_wdata,
    output wire        hs_ready,
    output wire        hs_error,
    output wire [31:0] hs_rdata,
    // high speed bus master port
    output wire        m_req,
    output wire        m_write,
    output wire [31:0] m_addr,
    output wire [31:0] m_wdata,
    input  wire        m_done,
    input  wire        m_error,
    input  wire [31:0] m_rdata,
    // interrupt
    output wire        irq
);

    // ************************************************
    // states and functions
    // ************************************************
    localparam [1:0] S_IDLE   = 2'd0;
    localparam [1:0] S_MASTER = 2'd1;
    localparam [1:0] S_RESP   = 2'd2;

    localparam [6:0] CHAN_CNT = 7'd`CHANNELS;

    // channel enable lookup over both enable words
    function chan_enabled;
        input [5:0]  idx;
        input [31:0] hi;
        input [31:0] lo;
        reg   [63:0] all;
        begin
            all = {hi, lo};
            chan_enabled = all[idx];
        end
    endfunction

    // ************************************************
    // registers
    // ************************************************
    reg        enabled_reg;
    reg        setup_reg;
    reg        berr_reg;
    reg        open_reg;
    reg [7:0]  window_reg;
    reg [7:0]  secret_reg;
    reg [31:0] en_high_reg;
    reg [31:0] en_low_reg;
    reg [1:0]  state_reg;
    reg        err_reg;
    reg [31:0] hs_rdata_reg;
    reg [31:0] m_addr_reg;
    reg [31:0] m_wdata_reg;
    reg        m_write_reg;
    reg [31:0] pb_rdata_reg;
    reg [31:0] remap_mem [0:`CHANNELS-1];

    wire [7:0] flags;
    wire [7:0] mask;
    wire       unlocked;
    wire [5:0] cur_chan;
    wire       expired;

    // ************************************************
    // fast bus decode
    // ************************************************
    wire [5:0] hs_idx    = hs_addr[7:2];
    wire       is_unlock = (hs_addr == `UNLOCK_OFF);
    wire       in_range  = ({1'b0, hs_idx} < CHAN_CNT);
    wire       take      = clk_en & hs_req & (state_reg == S_IDLE);
    wire       err_any   = |(flags & `ERR_MASK);
    wire [7:0] ur_key    = hs_wdata[`UR_KEY_HI:`UR_KEY_LO];
    wire       key_ok    = (ur_key == secret_reg);

    wire ur_write  = take & is_unlock & hs_write;
    wire ur_read   = take & is_unlock & ~hs_write;
    wire setup_acc = take & setup_reg & ~is_unlock;
    wire chan_try  = take & ~setup_reg & ~is_unlock;

    wire is_cur  = unlocked & (cur_chan == hs_idx);
    wire granted = enabled_reg & in_range
                   & chan_enabled(hs_idx, en_high_reg, en_low_reg)
                   & (open_reg | is_cur);

    wire target_bad = (hs_wdata[31:16] < `REMAP_FLOOR);
    wire rtr_write  = setup_acc & hs_write & in_range;
    wire unlock_go  = ur_write & ~err_any & key_ok;
    wire consume    = chan_try & granted & ~open_reg;
    wire m_finish   = clk_en & (state_reg == S_MASTER) & m_done;

    // ************************************************
    // events into the status word
    // ************************************************
    wire [7:0] set_ev;

    assign set_ev[`F_TIMEOUT] = expired;
    assign set_ev[`F_SUCCESS] = m_finish & ~m_error;
    assign set_ev[`F_DENIED]  = chan_try & ~granted;
    assign set_ev[`F_UNLOCK_PORT_READ_FLAG]  = ur_read;
    assign set_ev[`F_BADKEY]  = ur_write & ~err_any & ~key_ok;
    assign set_ev[`F_BLOCKED] = ur_write & err_any;
    assign set_ev[`F_MBERR]   = m_finish & m_error;
    assign set_ev[`F_REMAP]   = rtr_write & target_bad;

    // ************************************************
    // peripheral bus strobes
    // ************************************************
    wire pb_wr = clk_en & pb_sel & pb_write;
    wire pb_rd = clk_en & pb_sel & ~pb_write;

    wire ctrl_wr     = pb_wr & (pb_addr == `CTRL_OFF);
    wire config_wr   = pb_wr & (pb_addr == `CONFIG_OFF);
    wire en_high_wr  = pb_wr & (pb_addr == `EN_HIGH_OFF);
    wire en_low_wr   = pb_wr & (pb_addr == `EN_LOW_OFF);
    wire mask_set_wr = pb_wr & (pb_addr == `MASK_SET_OFF);
    wire mask_clr_wr = pb_wr & (pb_addr == `MASK_CLR_OFF);
    wire flag_clr_wr = pb_wr & (pb_addr == `FLAG_CLR_OFF);

    wire busy = (state_reg != S_IDLE);

    wire [31:0] status_word = {21'h0, busy, setup_reg,
                               enabled_reg, flags};

    // ************************************************
    // control and configuration
    // ************************************************
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            enabled_reg <= 1'b0;
            setup_reg   <= 1'b0;
            berr_reg    <= 1'b0;
            open_reg    <= 1'b0;
            window_reg  <= 8'h00;
            secret_reg  <= 8'h00;
            en_high_reg <= `RESET_WORD;
            en_low_reg  <= `RESET_WORD;
        end else if (clk_en) begin
            if (ctrl_wr) begin
                // disable wins when both bits are written together
                if (pb_wdata[`CTL_DIS])
                    enabled_reg <= 1'b0;
                else if (pb_wdata[`CTL_EN])
                    enabled_reg <= 1'b1;
                if (pb_wdata[`CTL_SETUP_OFF])
                    setup_reg <= 1'b0;
                else if (pb_wdata[`CTL_SETUP_ON])
                    setup_reg <= 1'b1;
                if (pb_wdata[`CTL_BERR_OFF])
                    berr_reg <= 1'b0;
                else if (pb_wdata[`CTL_BERR_ON])
                    berr_reg <= 1'b1;
            end
            if (config_wr) begin
                window_reg <= pb_wdata[`CFG_WIN_HI:`CFG_WIN_LO];
                secret_reg <= pb_wdata[`CFG_KEY_HI:`CFG_KEY_LO];
                open_reg   <= pb_wdata[`CFG_OPEN];
            end
            if (en_high_wr)
                en_high_reg <= pb_wdata;
            if (en_low_wr)
                en_low_reg <= pb_wdata;
        end
    end

    // ************************************************
    // peripheral bus read data
    // ************************************************
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pb_rdata_reg <= `RESET_WORD;
        end else if (pb_rd) begin
            case (pb_addr)
                `EN_HIGH_OFF: pb_rdata_reg <= en_high_reg;
                `EN_LOW_OFF:  pb_rdata_reg <= en_low_reg;
                `STATUS_OFF:  pb_rdata_reg <= status_word;
                `MASK_OFF:    pb_rdata_reg <= {24'h000000, mask};
                `PARAM_OFF:   pb_rdata_reg <= `PARAM_VAL;
                `VERSION_OFF: pb_rdata_reg <= `VERSION_VAL;
                // write-only and unmapped offsets read as zero
                default:      pb_rdata_reg <= `RESET_WORD;
            endcase
        end
    end

    // ************************************************
    // remap target storage
    // ************************************************
    always @(posedge ref_clk) begin
        // illegal targets are flagged and not stored
        if (rtr_write && !target_bad)
            remap_mem[hs_idx[2:0]] <= hs_wdata;
    end

    // ************************************************
    // fast bus transfer sequencer
    // ************************************************
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= S_IDLE;
            err_reg      <= 1'b0;
            hs_rdata_reg <= `RESET_WORD;
            m_addr_reg   <= `RESET_WORD;
            m_wdata_reg  <= `RESET_WORD;
            m_write_reg  <= 1'b0;
        end else if (clk_en) begin
            case (state_reg)
                S_IDLE: begin
                    err_reg <= 1'b0;
                    if (hs_req) begin
                        state_reg <= S_RESP;
                        if (setup_acc && !hs_write) begin
                            if (in_range)
                                hs_rdata_reg <= remap_mem[hs_idx[2:0]];
                            else
                                hs_rdata_reg <= `RESET_WORD;
                        end else if (ur_read) begin
                            hs_rdata_reg <= `RESET_WORD;
                            err_reg      <= berr_reg;
                        end else if (chan_try && granted) begin
                            // forward to the stored target
                            state_reg   <= S_MASTER;
                            m_addr_reg  <= remap_mem[hs_idx[2:0]];
                            m_wdata_reg <= hs_wdata;
                            m_write_reg <= hs_write;
                        end else if (chan_try) begin
                            hs_rdata_reg <= `RESET_WORD;
                            err_reg      <= berr_reg;
                        end
                    end
                end
                S_MASTER: begin
                    if (m_done) begin
                        state_reg    <= S_RESP;
                        hs_rdata_reg <= m_write_reg ? `RESET_WORD : m_rdata;
                        err_reg      <= berr_reg & m_error;
                    end
                end
                S_RESP: begin
                    state_reg <= S_IDLE;
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // ************************************************
    // submodules
    // ************************************************
    status_flags u_status (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .clk_en      (clk_en),
        .set_ev      (set_ev),
        .mask_set_wr (mask_set_wr),
        .mask_clr_wr (mask_clr_wr),
        .flag_clr_wr (flag_clr_wr),
        .wr_bits     (pb_wdata[7:0]),
        .flags       (flags),
        .mask        (mask),
        .irq         (irq)
    );

    unlock_timer u_timer (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .clk_en      (clk_en),
        .unlock_go   (unlock_go),
        .unlock_chan (hs_wdata[`UR_CH_HI:`UR_CH_LO]),
        .window_len  (window_reg),
        .consume     (consume),
        .drop        (~enabled_reg),
        .unlocked    (unlocked),
        .cur_chan    (cur_chan),
        .expired     (expired)
    );

    // ************************************************
    // outputs
    // ************************************************
    assign pb_rdata = pb_rdata_reg;
    assign hs_ready = clk_en & (state_reg == S_RESP);
    assign hs_error = err_reg;
    assign hs_rdata = hs_rdata_reg;
    assign m_req    = (state_reg == S_MASTER);
    assign m_write  = m_write_reg;
    assign m_addr   = m_addr_reg;
    assign m_wdata  = m_wdata_reg;

endmodule // secure_access_remap
`default_nettype wire

// ### bench/secure_access_remap_chk.sv
// checker for the remap unit: answer timing, error answers, mask shadow
// assumes it is bound into secure_access_remap, one clock ref_clk
`timescale 1ns/1ps
`default_nettype none
module secure_access_remap_chk (
    // clock, reset, enable
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        clk_en,
    // peripheral bus
    input wire logic        pb_sel,
    input wire logic        pb_write,
    input wire logic [7:0]  pb_addr,
    input wire logic [31:0] pb_wdata,
    input wire logic [31:0] pb_rdata,
    // fast bus slave
    input wire logic        hs_req,
    input wire logic        hs_write,
    input wire logic [7:0]  hs_addr,
    input wire logic        hs_ready,
    input wire logic        hs_error,
    // fast bus master, interrupt
    input wire logic        m_req,
    input wire logic [31:0] m_addr,
    input wire logic        m_done,
    input wire logic        m_error,
    input wire logic        irq
);
    // ********
    // shadow of control state, then checks
    // ********
    logic [7:0] mask_reg;
    logic       berr_reg;
    logic       en_reg;
    logic       setup_reg;
    logic       busy_reg;
    wire        pw   = pb_sel & pb_write & clk_en;
    wire        take = hs_req & clk_en & ~busy_reg;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mask_reg  <= 8'h00;
            berr_reg  <= 1'b0;
            en_reg    <= 1'b0;
            setup_reg <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            if (pw && pb_addr == 8'h14)
                mask_reg <= mask_reg | pb_wdata[7:0];
            if (pw && pb_addr == 8'h18)
                mask_reg <= mask_reg & ~pb_wdata[7:0];
            if (pw && pb_addr == 8'h00) begin
                berr_reg  <= pb_wdata[5] ? 1'b0 : (pb_wdata[4] ? 1'b1 : berr_reg);
                en_reg    <= pb_wdata[1] ? 1'b0 : (pb_wdata[0] ? 1'b1 : en_reg);
                setup_reg <= pb_wdata[3] ? 1'b0 : (pb_wdata[2] ? 1'b1 : setup_reg);
            end
            busy_reg <= take | (busy_reg & ~hs_ready);
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    ready_pulse_a: assert property (hs_ready |=> !hs_ready)
        else $error("hs_ready longer than one cycle");
    unlock_local_a: assert property (take && hs_addr == 8'hfc |=> hs_ready && !m_req)
        else $error("unlock port access not answered locally");
    unlock_read_a: assert property (take && !hs_write && hs_addr == 8'hfc
        |=> hs_error == berr_reg)
        else $error("unlock port read answer wrong");
    denied_answer_a: assert property (take && !en_reg && !setup_reg && hs_addr != 8'hfc
        |=> hs_ready && !m_req && hs_error == berr_reg)
        else $error("disabled channel access answer wrong");
    master_hold_a: assert property (m_req && !m_done |=> m_req && $stable(m_addr))
        else $error("master request dropped or moved");
    master_cause_a: assert property ($rose(m_req)
        |-> $past(take && en_reg && !setup_reg))
        else $error("master request without enabled access");
    forward_ok_a: assert property (m_req && m_done && !m_error
        |=> hs_ready && !m_req && !hs_error)
        else $error("forwarded access answer wrong");
    forward_err_a: assert property (m_req && m_done && m_error
        |=> hs_ready && hs_error == berr_reg)
        else $error("master error answer wrong");
    mask_read_a: assert property (pb_sel && !pb_write && clk_en && pb_addr == 8'h1c
        |=> pb_rdata[7:0] == mask_reg)
        else $error("mask readback wrong");
    irq_masked_a: assert property (mask_reg == 8'h00 |-> !irq)
        else $error("irq with all mask bits clear");
    cover property (m_req && m_done && m_error);
    cover property (take && !hs_write && hs_addr == 8'hfc);
    cover property (m_req && m_done && !m_error);
    cover property (irq);
endmodule // secure_access_remap_chk
bind secure_access_remap secure_access_remap_chk secure_access_remap_chk_inst (.ref_clk, .nrst,
    .clk_en, .pb_sel, .pb_write, .pb_addr, .pb_wdata, .pb_rdata, .hs_req, .hs_write, .hs_addr,
    .hs_ready, .hs_error, .m_req, .m_addr, .m_done, .m_error, .irq);
`default_nettype wire

// ### bench/fast_slave_model.sv
// slave on the unit's master port: answers dly+1 cycles after m_req rises, errors on command
// assumes m_req is held until m_done, single clock ref_clk
`timescale 1ns/1ps
`default_nettype none
module fast_slave_model (
    // clock, reset
    input wire logic         ref_clk,
    input wire logic         nrst,
    // master port of the unit
    input wire logic         m_req,
    input wire logic         m_write,
    input wire logic [31:0]  m_addr,
    input wire logic [31:0]  m_wdata,
    output var logic         m_done,
    output wire logic        m_error,
    output wire logic [31:0] m_rdata,
    // bench control and record
    input wire logic [3:0]   dly,
    input wire logic         err_cmd,
    output var logic [31:0]  last_data
);
    // ********
    // answer timing and data
    // ********
    logic [3:0]  cnt_reg;
    logic [31:0] junk_reg;
    // read data only valid with m_done, toggling junk otherwise
    assign m_rdata = m_done ? (m_addr ^ 32'h5a5a0000) : junk_reg;
    assign m_error = m_done & err_cmd;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg   <= 4'h0;
            junk_reg  <= 32'h0;
            m_done    <= 1'b0;
            last_data <= 32'h0;
        end else begin
            junk_reg <= ~junk_reg;
            m_done   <= m_req & ~m_done & (cnt_reg == dly);
            cnt_reg  <= (m_req & ~m_done) ? cnt_reg + 4'h1 : 4'h0;
            if (m_done & m_write)
                last_data <= m_wdata;
        end
    end
endmodule // fast_slave_model
`default_nettype wire

// ### bench/secure_access_remap_bench.sv
// self-checking bench: register, setup, unlock, error and forwarding tests
// assumes the checker is bound by its own file and the slave model beside
`timescale 1ns/1ps
`default_nettype none
`include "secure_remap_map.vh"
module secure_access_remap_bench;
    // ********
    // signals, instances, tasks, tests
    // ********
    logic        ref_clk, nrst, clk_en, pb_sel, pb_write, hs_req, hs_write;
    logic [7:0]  pb_addr, hs_addr;
    logic [31:0] pb_wdata, pb_rdata, hs_wdata, hs_rdata, hs_rd;
    logic        hs_ready, hs_error, m_req, m_write, m_done, m_error, irq, err_cmd;
    logic [31:0] m_addr, m_wdata, m_rdata, last_data;
    logic [3:0]  dly;
    int          n_fail, cmp_count, i;
    secure_access_remap secure_access_remap_inst (.ref_clk, .nrst, .clk_en, .pb_sel,
        .pb_write, .pb_addr, .pb_wdata, .pb_rdata, .hs_req, .hs_write, .hs_addr, .hs_wdata,
        .hs_ready, .hs_error, .hs_rdata, .m_req, .m_write, .m_addr, .m_wdata, .m_done,
        .m_error, .m_rdata, .irq);
    fast_slave_model fast_slave_model_inst (.ref_clk, .nrst, .m_req, .m_write, .m_addr,
        .m_wdata, .m_done, .m_error, .m_rdata, .dly, .err_cmd, .last_data);
    always #25 ref_clk = ~ref_clk;
    task check(input logic [31:0] got, input logic [31:0] exp, input logic [7:0] id);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: item %h got %h expected %h", $time, id, got, exp);
        end
    endtask
    task pb(input logic w, input logic [7:0] a, input logic [31:0] d);
        pb_sel <= 1'b1;
        pb_write <= w;
        pb_addr <= a;
        pb_wdata <= d;
        @(posedge ref_clk);
        pb_sel <= 1'b0;
        #1;
        if (!w)
            check(pb_rdata, d, a);
        @(posedge ref_clk);
    endtask
    task hs(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        int n;
        hs_req <= 1'b1;
        hs_write <= w;
        hs_addr <= a;
        hs_wdata <= d;
        n = 0;
        @(negedge ref_clk);
        while (hs_ready !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        check({30'h0, hs_ready, hs_error}, {30'h0, 1'b1, e}, a);
        hs_rd = hs_rdata;
        @(posedge ref_clk);
        hs_req <= 1'b0;
        @(posedge ref_clk);
    endtask
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge ref_clk);
        n_fail++;
        $display("mismatch at %0t: watchdog ran out", $time);
        finish_test;
    end
    initial begin
        {ref_clk, nrst, pb_sel, pb_write, hs_req, hs_write, err_cmd} = 7'h0;
        clk_en = 1'b1;
        {pb_addr, hs_addr, pb_wdata, hs_wdata, dly} = 84'h0;
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        for (i = 0; i < 12; i++)
            pb(1'b0, 8'(i * 4), i == 9 ? `PARAM_VAL : (i == 10 ? `VERSION_VAL : 32'h0));
        pb(1'b1, 8'h24, 32'hffffffff);
        pb(1'b0, 8'h24, `PARAM_VAL);
        pb(1'b1, 8'h08, 32'ha5a55a5a);
        pb(1'b0, 8'h08, 32'ha5a55a5a);
        pb(1'b1, 8'h0c, 32'h00000001);
        pb(1'b0, 8'h0c, 32'h00000001);
        pb(1'b1, 8'h14, 32'h0000000f);
        pb(1'b1, 8'h14, 32'h00000030);
        pb(1'b1, 8'h18, 32'h00000003);
        pb(1'b0, 8'h1c, 32'h0000003c);
        pb(1'b1, 8'h14, 32'h000000ff);
        pb(1'b1, 8'h00, 32'h00000005);
        pb(1'b1, 8'h00, 32'h00000000);
        pb(1'b0, 8'h10, 32'h00000300);
        $display("test registers done");
        hs(1'b1, 8'h00, 32'hfffc0010, 1'b0);
        hs(1'b1, 8'h04, 32'hfffbfffc, 1'b0);
        pb(1'b0, 8'h10, 32'h00000380);
        hs(1'b0, 8'h00, 32'h0, 1'b0);
        check(hs_rd, 32'hfffc0010, 8'h00);
        check({31'h0, irq}, 32'h1, 8'h10);
        pb(1'b1, 8'h20, 32'h00000080);
        pb(1'b0, 8'h10, 32'h00000300);
        check({31'h0, irq}, 32'h0, 8'h10);
        pb(1'b1, 8'h00, 32'h00000008);
        pb(1'b1, 8'h04, 32'h0000043c);
        $display("test setup done");
        for (i = 0; i < 2; i++) begin
            pb(1'b1, 8'h00, i ? 32'h10 : 32'h20);
            hs(1'b0, 8'h00, 32'h0, i[0]);
            pb(1'b0, 8'h10, 32'h00000104);
            hs(1'b0, 8'hfc, 32'h0, i[0]);
            pb(1'b0, 8'h10, 32'h0000010c);
            pb(1'b1, 8'h20, 32'h000000ff);
        end
        hs(1'b1, 8'hfc, 32'h0000003d, 1'b0);
        pb(1'b0, 8'h10, 32'h00000110);
        hs(1'b1, 8'hfc, 32'h0000003c, 1'b0);
        hs(1'b0, 8'h00, 32'h0, 1'b1);
        pb(1'b0, 8'h10, 32'h00000134);
        pb(1'b1, 8'h20, 32'h000000ff);
        $display("test errors done");
        dly <= 4'h6;
        hs(1'b1, 8'hfc, 32'h0000003c, 1'b0);
        fork
            hs(1'b0, 8'h00, 32'h0, 1'b0);
            begin
                repeat (3) @(posedge ref_clk);
                pb(1'b0, 8'h10, 32'h00000500);
            end
        join
        check(hs_rd, 32'hfffc0010 ^ 32'h5a5a0000, 8'h00);
        pb(1'b0, 8'h10, 32'h00000102);
        dly <= 4'h0;
        err_cmd <= 1'b1;
        hs(1'b1, 8'hfc, 32'h0000003c, 1'b0);
        // frozen edges must not run the unlock window down
        clk_en <= 1'b0;
        repeat (10) @(posedge ref_clk);
        clk_en <= 1'b1;
        hs(1'b1, 8'h00, 32'hcafe0001, 1'b1);
        check(last_data, 32'hcafe0001, 8'h00);
        pb(1'b1, 8'h20, 32'h00000002);
        pb(1'b0, 8'h10, 32'h00000140);
        pb(1'b1, 8'h20, 32'h000000ff);
        err_cmd <= 1'b0;
        $display("test forwarding done");
        hs(1'b1, 8'hfc, 32'h0000003c, 1'b0);
        repeat (8) @(posedge ref_clk);
        pb(1'b0, 8'h10, 32'h00000101);
        hs(1'b0, 8'h00, 32'h0, 1'b1);
        pb(1'b1, 8'h20, 32'h000000ff);
        pb(1'b0, 8'h10, 32'h00000100);
        pb(1'b1, 8'h00, 32'h00000003);
        pb(1'b0, 8'h10, 32'h00000000);
        hs(1'b0, 8'h00, 32'h0, 1'b1);
        $display("test timeout and disable done");
        finish_test;
    end
endmodule // secure_access_remap_bench
`default_nettype wire
